// ### hsfc_addr_decode.sv
// hsfc_addr_decode: maps two four-state straps onto one of 16 addresses
// assumes straps are already resolved to their connection state
`timescale 1ns/100ps
`default_nettype none
module hsfc_addr_decode import hsfc_pkg::*; #(
  parameter logic [6:0] BASE_ADDR = 7'h40 // arbitrary base
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire hsfc_strap_t address_strap_a_i,
  input wire hsfc_strap_t address_strap_b_i,
  output logic [6:0] addr_o
);
  logic [6:0] addr_ff;
  logic [6:0] nxt_addr;

  // four states per strap give sixteen addresses
  always_comb begin
    nxt_addr = BASE_ADDR | {3'h0, address_strap_b_i, address_strap_a_i}; // RQ14
  end

  // register the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= BASE_ADDR;
    end else begin
      addr_ff <= nxt_addr;
    end
  end
  assign addr_o = addr_ff;
endmodule : hsfc_addr_decode
`default_nettype wire

// ### hsfc_asserts.sv
// hsfc_asserts: port level checks of the hot swap fault control
// assumes it is bound to hsfc_top and every input runs on clk_i
`timescale 1ns/100ps
`default_nettype none
module hsfc_asserts import hsfc_pkg::*; #(
  parameter bit ACTIVE_LOW_EN = 1'b0,
  parameter int LW = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic retry_sel_i,
  input wire hsfc_sense_t sense_i,
  input wire logic [LW-1:0] normal_limit_ref_i,
  input wire logic [LW-1:0] foldback_ref_i,
  input wire logic gate_on_o,
  input wire logic fault_oe_o,
  input wire logic power_good_out_o,
  input wire logic [LW-1:0] limit_o
);
  logic en_act;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // enable pin seen in its active sense
  assign en_act = enable_i ^ ACTIVE_LOW_EN;
  // gate shutdown and start conditions
  property p_timer;
    sense_i.timer_over |=> !gate_on_o;
  endproperty
  a_timer: assert property (p_timer) else $error("gate on past timer");
  property p_uvlo;
    sense_i.uvlo |=> !gate_on_o;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("gate on in lockout");
  property p_no_start;
    !en_act && !gate_on_o |=> !gate_on_o;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start while off");
  // fault latch and power-good
  property p_fault_set;
    gate_on_o && (sense_i.timer_over || sense_i.over_temp || sense_i.fet_bad)
      |-> ##[1:2] fault_oe_o;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault missed");
  property p_fault_hold;
    fault_oe_o && retry_sel_i && !en_act |=> fault_oe_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
  property p_pg;
    $rose(power_good_out_o) |-> !fault_oe_o &&
      $past(sense_i.out_in_tol && sense_i.gate_full && en_act);
  endproperty
  a_pg: assert property (p_pg) else $error("power good early");
  // current limit selection
  property p_lim_min;
    limit_o <= $past(normal_limit_ref_i) && limit_o <= $past(foldback_ref_i);
  endproperty
  a_lim_min: assert property (p_lim_min) else $error("limit too high");
  property p_lim_pg;
    power_good_out_o && $past(power_good_out_o) |-> limit_o ==
      ($past(normal_limit_ref_i) < $past(foldback_ref_i) ?
      $past(normal_limit_ref_i) : $past(foldback_ref_i));
  endproperty
  a_lim_pg: assert property (p_lim_pg) else $error("start limit stuck");
endmodule : hsfc_asserts
bind hsfc_top hsfc_asserts #(.ACTIVE_LOW_EN(ACTIVE_LOW_EN), .LW(LW)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
  .retry_sel_i(retry_sel_i), .sense_i(sense_i),
  .normal_limit_ref_i(normal_limit_ref_i), .foldback_ref_i(foldback_ref_i),
  .gate_on_o(gate_on_o), .fault_oe_o(fault_oe_o),
  .power_good_out_o(power_good_out_o), .limit_o(limit_o)
);
`default_nettype wire

// ### hsfc_board_model.sv
// hsfc_board_model: fet, sense circuits and board controller around the block
// assumes fault levels come from the bench as {uvlo,timer,temp,fet}
`timescale 1ns/100ps
`default_nettype none
module hsfc_board_model import hsfc_pkg::*; (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic slow_i,
  input wire logic [3:0] fault_i,
  input wire logic conversion_trigger_pull_i,
  input wire logic pin_one_oe_i,
  output hsfc_sense_t sense_o,
  output logic pin_one_o
);
  int ramp_cnt = 0;
  logic full;
  // the fet reaches full enhancement a while after the gate turns on
  always @(posedge clk_i) begin
    if (!gate_i) ramp_cnt <= 0;
    else if (ramp_cnt < 40) ramp_cnt <= ramp_cnt + 1;
  end
  assign full = gate_i && (ramp_cnt >= (slow_i ? 30 : 3));
  assign sense_o = {fault_i, full, full};
  // pin one is wired-and with a pull-up; the controller pulls it to convert
  assign pin_one_o = !(pin_one_oe_i || conversion_trigger_pull_i);
endmodule : hsfc_board_model
`default_nettype wire

// ### hsfc_limit_sel.sv
// hsfc_limit_sel: computes the start-up limit and picks the lowest active one
// assumes limit references arrive as unsigned codes on clk_i
`timescale 1ns/100ps
`default_nettype none
module hsfc_limit_sel import hsfc_pkg::*; #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] normal_limit_ref_i,
  input wire logic [W-1:0] startup_limit_ref_i,
  input wire logic [W-1:0] foldback_ref_i,
  input wire logic [3:0] startup_limit_code_i,
  input wire logic power_good_i,
  output logic [W-1:0] limit_o
);
  logic [W-1:0] limit_ff;
  logic [W-1:0] nxt_limit;
  logic [W+3:0] prod;
  logic [W-1:0] code_lim;
  logic [W-1:0] start_lim;

  // pick lowest of the active limits
  always_comb begin
    prod = normal_limit_ref_i * startup_limit_code_i;
    code_lim = prod[W+3:LIMIT_DIV_SHIFT]; // RQ7
    start_lim = (code_lim < startup_limit_ref_i) ? code_lim
                                                 : startup_limit_ref_i;
    nxt_limit = (foldback_ref_i < normal_limit_ref_i) ? foldback_ref_i
                                                      : normal_limit_ref_i;
    if (!power_good_i && start_lim < nxt_limit) begin // RQ6 RQ8
      nxt_limit = start_lim;
    end
  end

  // register the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_ff <= '0;
    end else begin
      limit_ff <= nxt_limit;
    end
  end
  assign limit_o = limit_ff;
endmodule : hsfc_limit_sel
`default_nettype wire

// ### hsfc_pkg.sv
// hsfc_pkg: constants, types and register map of the hot swap fault control
// assumes a 125 MHz clock and a classic wishbone register bus
package hsfc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned RETRY_DELAY_S = 10;
  localparam longint unsigned RETRY_CYCLES = longint'(RETRY_DELAY_S) * CLK_HZ;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_LIMIT = 8'h10;
  localparam logic [7:0] OFS_PINCFG = 8'h14;
  localparam logic [7:0] OFS_ALSEL = 8'h18;
  localparam logic [7:0] OFS_ADDR = 8'h1C;
  // reset values
  localparam logic [3:0] STARTUP_CODE_RST = 4'hF;
  localparam logic [3:0] ALSEL_RST = 4'hF;
  localparam logic [3:0] MASK_RST = 4'h0;
  // pin modes: alert is the power-up default
  localparam logic [1:0] PIN_ALERT = 2'h0;
  localparam logic [1:0] PIN_GPO = 2'h1;
  localparam logic [1:0] PIN_CONVERSION_TRIGGER = 2'h2;
  localparam int unsigned LIMIT_DIV_SHIFT = 4; // divide by 16
  // event bit positions in irq / mask / alert select
  localparam int unsigned EV_OC = 0;
  localparam int unsigned EV_OT = 1;
  localparam int unsigned EV_FET = 2;
  localparam int unsigned EV_PG = 3;

  // strap connection states
  typedef enum logic [1:0] {
    HSFC_STRAP_GND = 2'h0,
    HSFC_STRAP_RES = 2'h1,
    HSFC_STRAP_FLT = 2'h2,
    HSFC_STRAP_VCAP = 2'h3
  } hsfc_strap_t;

  // gray coded sequencer states
  typedef enum logic [2:0] {
    HSFC_OFF = 3'h0,
    HSFC_RAMP = 3'h1,
    HSFC_ON = 3'h3,
    HSFC_FAULT = 3'h2,
    HSFC_WAIT = 3'h6
  } hsfc_state_t;

  // analog side status bundle
  typedef struct packed {
    logic uvlo;
    logic timer_over;
    logic over_temp;
    logic fet_bad;
    logic out_in_tol;
    logic gate_full;
  } hsfc_sense_t;

  // wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } hsfc_wb_req_t;
endpackage : hsfc_pkg

// ### hsfc_top.sv
// hsfc_top: enable, fault latch, gate control, retry, alerts and registers
// assumes all inputs synchronous to clk_i and a classic wishbone master
// assumes open-drain pin buffers outside, switched by the *_oe_o enables
// the default retry count spans ten seconds at 125 MHz
// Functional notes
// (RQ1) active-high variant starts power-up only while enable is high.
// (RQ2) active-low variant starts power-up only while enable is low.
// (RQ3) a fault drives the fault output low and keeps it latched.
// (RQ4) overcurrent timer expiry, overtemperature or FET health set the fault.
// (RQ5) the gate is pulled low as soon as the timer passes its upper threshold.
// (RQ6) the start-up limit applies only while power-good is low.
// (RQ7) start-up limit from the bus is the normal limit times code over 16.
// (RQ8) the lowest of all active current limits is enforced.
// (RQ9) both multipurpose pins come up as open-drain alert outputs.
// (RQ10) an alert pin asserts while any selected condition is present.
// (RQ11) pin one as conversion input lets the controller start sampling.
// (RQ12) with retry-select high the device latches off after overcurrent.
// (RQ13) with retry-select low it retries 10 seconds after an overcurrent.
// (RQ14) two four-state straps decode into 16 bus addresses.
// (RQ15) power-good needs output in tolerance, no fault, enable, full gate.
// (RQ16) the gate is held low while the supply is under lockout.
// (RQ17) cycling enable off and on clears a latched fault first.
`timescale 1ns/100ps
`default_nettype none
module hsfc_top import hsfc_pkg::*; #(
  parameter bit ACTIVE_LOW_EN = 1'b0,
  parameter int LW = 12,
  parameter longint unsigned RETRY_CNT = RETRY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic enable_i,
  input wire logic retry_sel_i,
  input wire hsfc_sense_t sense_i,
  input wire logic [LW-1:0] normal_limit_ref_i,
  input wire logic [LW-1:0] startup_limit_ref_i,
  input wire logic [LW-1:0] foldback_ref_i,
  input wire hsfc_strap_t address_strap_a_i,
  input wire hsfc_strap_t address_strap_b_i,
  input wire logic pin_one_i,
  output logic gate_on_o,
  output logic fault_oe_o,
  output logic power_good_out_o,
  output logic pin_one_oe_o,
  output logic pin_two_oe_o,
  output logic conversion_trigger_o,
  output logic [LW-1:0] limit_o,
  output logic [6:0] bus_addr_o,
  output logic irq_o
);
  localparam int CW = $clog2(RETRY_CNT + 1);
  localparam logic [CW-1:0] RETRY_LAST = CW'(RETRY_CNT - 1);
  // the retry counter is sized from the cycle count, so a short count in
  // simulation and the full count in silicon share one design

  // bus request bundle, sequencer state and retry counter
  hsfc_wb_req_t req;
  hsfc_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic fault_ff, nxt_fault;
  logic oc_ff, nxt_oc;
  logic pg_ff, nxt_pg;
  logic en_prev_ff;
  logic en_act;
  logic en_rise;
  logic [3:0] events;
  // register file
  logic [3:0] irq_ff, nxt_irq;
  logic [3:0] mask_ff, nxt_mask;
  logic [3:0] alsel_ff, nxt_alsel;
  logic [3:0] code_ff, nxt_code;
  logic [1:0] mode1_ff, nxt_mode1;
  logic [1:0] mode2_ff, nxt_mode2;
  logic [1:0] gpo_ff, nxt_gpo;
  // bus answer, gate and pin drivers
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic gate_ff, nxt_gate;
  logic p1_ff, nxt_p1, p2_ff, nxt_p2;
  logic conversion_trigger_ff, nxt_conversion_trigger, pin1_prev_ff;
  logic irq_out_ff, nxt_irq_out;
  // decoded write strobe and alert matches
  logic wr;
  logic alert_hit1, alert_hit2;

  assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};
  assign en_act = ACTIVE_LOW_EN ? !enable_i : enable_i; // RQ1 RQ2
  // the enable edge is taken in its active sense, so both polarities
  // release a latched fault the same way
  assign en_rise = en_act && !en_prev_ff;
  // a write lands only on the taking edge; the ack that follows keeps a
  // held request from writing twice
  assign wr = req.cyc && req.stb && req.we && !ack_ff && req.sel[0];

  // sequencer: enable, fault latch and retry timing
  // usual path: off -> ramp -> on; a fault source in any state but fault
  // itself goes to fault; an overcurrent with auto retry then waits the
  // retry count and drops back to off with the fault cleared
  // a start is refused while disabled, under lockout or with a fault held
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_fault = fault_ff;
    nxt_oc = oc_ff;
    case (state_ff)
      HSFC_OFF: begin
        // an enable edge is the only way out of latch-off
        if (en_rise) begin
          nxt_fault = 1'b0; // RQ17
        end
        if (en_act && !sense_i.uvlo && !fault_ff) begin // RQ1 RQ2
          nxt_state = HSFC_RAMP;
        end
      end
      HSFC_RAMP, HSFC_ON: begin
        // ramp ends once the fet is fully enhanced
        if (sense_i.gate_full && state_ff == HSFC_RAMP) begin
          nxt_state = HSFC_ON;
        end
        if (!en_act || sense_i.uvlo) begin
          nxt_state = HSFC_OFF;
        end
      end
      HSFC_FAULT: begin
        // auto retry only after overcurrent; else wait for enable to drop
        if (oc_ff && !retry_sel_i) begin // RQ13
          nxt_state = HSFC_WAIT;
          nxt_cnt = '0;
        end else if (!en_act) begin // RQ12
          nxt_state = HSFC_OFF;
        end
      end
      HSFC_WAIT: begin
        // dropping enable during the wait abandons the retry
        nxt_cnt = cnt_ff + CW'(1);
        if (!en_act) begin
          nxt_state = HSFC_OFF;
        end else if (cnt_ff == RETRY_LAST) begin // RQ13
          nxt_state = HSFC_OFF;
          nxt_fault = 1'b0;
        end
      end
      default: nxt_state = HSFC_OFF;
    endcase
    // fault sources latch the fault from any active state
    // only a pure timer expiry counts as overcurrent, so a hot or damaged
    // fet never restarts by itself
    if (state_ff != HSFC_FAULT &&
        (sense_i.timer_over || sense_i.over_temp || sense_i.fet_bad)) begin
      nxt_fault = 1'b1; // RQ3 RQ4
      nxt_oc = sense_i.timer_over && !sense_i.over_temp && !sense_i.fet_bad;
      nxt_state = HSFC_FAULT;
    end
  end

  // gate drive and power-good
  // both look at the next state, so the gate drops on the same edge that
  // latches a fault and not one cycle later
  always_comb begin
    nxt_gate = (nxt_state == HSFC_RAMP || nxt_state == HSFC_ON)
               && !sense_i.timer_over && !sense_i.uvlo; // RQ5 RQ16
    nxt_pg = sense_i.out_in_tol && !nxt_fault && en_act
             && sense_i.gate_full && nxt_gate; // RQ15
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= HSFC_OFF;
      cnt_ff <= '0;
      fault_ff <= 1'b0;
      oc_ff <= 1'b0;
      gate_ff <= 1'b0;
      pg_ff <= 1'b0;
      en_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      fault_ff <= nxt_fault;
      oc_ff <= nxt_oc;
      gate_ff <= nxt_gate;
      pg_ff <= nxt_pg;
      en_prev_ff <= en_act;
    end
  end

  // event sources for interrupt and alert
  // power-good lost is taken as its edge from high to low
  always_comb begin
    events = '0;
    events[EV_OC] = sense_i.timer_over;
    events[EV_OT] = sense_i.over_temp;
    events[EV_FET] = sense_i.fet_bad;
    events[EV_PG] = pg_ff && !nxt_pg;
  end

  // register writes, sticky status and interrupt
  // byte offsets: 00 control (ro), 04 status (ro), 08 sticky events
  // (write one to clear), 0C event mask, 10 start-up limit code,
  // 14 pin modes and output levels, 18 alert select, 1C strap address
  // every field sits in byte 0, so a write without sel[0] is ignored
  always_comb begin
    nxt_irq = irq_ff;
    nxt_mask = mask_ff;
    nxt_alsel = alsel_ff;
    nxt_code = code_ff;
    nxt_mode1 = mode1_ff;
    nxt_mode2 = mode2_ff;
    nxt_gpo = gpo_ff;
    if (wr) begin
      case (req.adr)
        OFS_IRQ: nxt_irq = irq_ff & ~req.dat[3:0];
        OFS_MASK: nxt_mask = req.dat[3:0];
        OFS_LIMIT: nxt_code = req.dat[3:0]; // RQ7
        OFS_PINCFG: begin
          nxt_mode1 = req.dat[1:0];
          nxt_mode2 = (req.dat[3:2] == PIN_CONVERSION_TRIGGER) ? mode2_ff : req.dat[3:2];
          nxt_gpo = req.dat[5:4];
        end
        OFS_ALSEL: nxt_alsel = req.dat[3:0];
        default: ;
      endcase
    end
    nxt_irq = nxt_irq | events; // set wins over clear
    nxt_irq_out = |(nxt_irq & nxt_mask);
  end

  // read mux and single-cycle ack
  // read data is captured on the taking edge and stands with the ack
  // an unmapped offset is acked and reads as zero
  always_comb begin
    nxt_ack = req.cyc && req.stb && !ack_ff;
    nxt_rdat = '0;
    case (req.adr)
      OFS_CTRL: nxt_rdat = {31'h0, ACTIVE_LOW_EN};
      OFS_STAT: nxt_rdat = {24'h0, 2'h0, state_ff, pg_ff, fault_ff, gate_ff};
      OFS_IRQ: nxt_rdat = {28'h0, irq_ff};
      OFS_MASK: nxt_rdat = {28'h0, mask_ff};
      OFS_LIMIT: nxt_rdat = {28'h0, code_ff};
      OFS_PINCFG: nxt_rdat = {26'h0, gpo_ff, mode2_ff, mode1_ff};
      OFS_ALSEL: nxt_rdat = {28'h0, alsel_ff};
      OFS_ADDR: nxt_rdat = {25'h0, bus_addr_o};
      default: nxt_rdat = '0;
    endcase
  end

  // multipurpose pins: alert, general output or conversion input
  // an enable of one pulls the open-drain pin low; alert mode is the
  // power-up default, and conversion mode releases pin one so that the
  // controller can pull it; a falling level on it starts a sampling cycle
  always_comb begin
    alert_hit1 = |(irq_ff & alsel_ff); // RQ10
    alert_hit2 = alert_hit1;
    case (mode1_ff)
      PIN_ALERT: nxt_p1 = alert_hit1; // RQ9
      PIN_GPO: nxt_p1 = !gpo_ff[0];
      default: nxt_p1 = 1'b0;
    endcase
    case (mode2_ff)
      PIN_ALERT: nxt_p2 = alert_hit2; // RQ9
      PIN_GPO: nxt_p2 = !gpo_ff[1];
      default: nxt_p2 = 1'b0;
    endcase
    nxt_conversion_trigger = (mode1_ff == PIN_CONVERSION_TRIGGER) && !pin_one_i && pin1_prev_ff; // RQ11
  end

  // register file and pin registers
  // pin one's last level resets high, its pulled-up idle level, so no
  // false conversion edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= '0;
      mask_ff <= MASK_RST;
      alsel_ff <= ALSEL_RST;
      code_ff <= STARTUP_CODE_RST;
      mode1_ff <= PIN_ALERT;
      mode2_ff <= PIN_ALERT;
      gpo_ff <= '0;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
      conversion_trigger_ff <= 1'b0;
      pin1_prev_ff <= 1'b1;
      irq_out_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
      mask_ff <= nxt_mask;
      alsel_ff <= nxt_alsel;
      code_ff <= nxt_code;
      mode1_ff <= nxt_mode1;
      mode2_ff <= nxt_mode2;
      gpo_ff <= nxt_gpo;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
      conversion_trigger_ff <= nxt_conversion_trigger;
      pin1_prev_ff <= pin_one_i;
      irq_out_ff <= nxt_irq_out;
    end
  end

  // lowest-limit selection
  // power-good from its flip-flop ends the start-up limit one cycle later
  hsfc_limit_sel #(.W(LW)) u_limit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .normal_limit_ref_i(normal_limit_ref_i),
    .startup_limit_ref_i(startup_limit_ref_i),
    .foldback_ref_i(foldback_ref_i),
    .startup_limit_code_i(code_ff),
    .power_good_i(pg_ff),
    .limit_o(limit_o)
  );

  // strap address decode
  // straps are sampled every cycle; a board fixes them at assembly
  hsfc_addr_decode u_addr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .address_strap_a_i(address_strap_a_i),
    .address_strap_b_i(address_strap_b_i),
    .addr_o(bus_addr_o)
  );

  // every output comes straight from a flip-flop
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign gate_on_o = gate_ff;
  assign fault_oe_o = fault_ff; // RQ3
  assign power_good_out_o = pg_ff;
  assign pin_one_oe_o = p1_ff;
  assign pin_two_oe_o = p2_ff;
  assign conversion_trigger_o = conversion_trigger_ff;
  assign irq_o = irq_out_ff;
endmodule : hsfc_top
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench of the hot swap fault control
// assumes hsfc_top with a short retry count and the board model beside it
`timescale 1ns/100ps
`default_nettype none
module tb_top import hsfc_pkg::*;;
  localparam int RC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic rsel = 1'b1;
  logic slow = 1'b0;
  logic conversion_trigger = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [3:0] code;
  logic [11:0] nref = 12'h0;
  logic [11:0] sref = 12'h0;
  logic [11:0] fref = 12'h0;
  logic [3:0] strap = 4'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [11:0] lim;
  logic [6:0] badr;
  logic pin1, gate, fault, pg, oe1, oe2, trig, irq, ack;
  logic gate_lo;
  hsfc_wb_req_t req = '0;
  hsfc_sense_t sense;
  int fail_count = 0;
  int num_checks = 0;
  int hits;
  logic [7:0] ofs [5] = '{OFS_LIMIT, OFS_ALSEL, OFS_MASK, OFS_CTRL, 8'h40};
  logic [31:0] rst_val [5] = '{32'hF, 32'hF, 32'h0, 32'h0, 32'h0};

  hsfc_top #(.RETRY_CNT(RC)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .enable_i(en),
    .retry_sel_i(rsel), .sense_i(sense), .normal_limit_ref_i(nref),
    .startup_limit_ref_i(sref), .foldback_ref_i(fref),
    .address_strap_a_i(hsfc_strap_t'(strap[1:0])),
    .address_strap_b_i(hsfc_strap_t'(strap[3:2])), .pin_one_i(pin1),
    .gate_on_o(gate), .fault_oe_o(fault), .power_good_out_o(pg),
    .pin_one_oe_o(oe1), .pin_two_oe_o(oe2), .conversion_trigger_o(trig),
    .limit_o(lim), .bus_addr_o(badr), .irq_o(irq)
  );
  // active-low variant beside it, run from the inverted enable
  hsfc_top #(.ACTIVE_LOW_EN(1'b1), .RETRY_CNT(RC)) i_dut_low (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_dat_o(), .wb_ack_o(), .enable_i(!en),
    .retry_sel_i(rsel), .sense_i(sense), .normal_limit_ref_i(nref),
    .startup_limit_ref_i(sref), .foldback_ref_i(fref),
    .address_strap_a_i(hsfc_strap_t'(strap[1:0])),
    .address_strap_b_i(hsfc_strap_t'(strap[3:2])), .pin_one_i(pin1),
    .gate_on_o(gate_lo), .fault_oe_o(), .power_good_out_o(),
    .pin_one_oe_o(), .pin_two_oe_o(), .conversion_trigger_o(),
    .limit_o(), .bus_addr_o(), .irq_o()
  );
  hsfc_board_model i_board (
    .clk_i(clk_i), .gate_i(gate), .slow_i(slow), .fault_i(flt),
    .conversion_trigger_pull_i(conversion_trigger), .pin_one_oe_i(oe1), .sense_o(sense), .pin_one_o(pin1)
  );

  // clock at 125 MHz
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // compare one result and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, waiting for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    rd = dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask : wb

  // wait for gate (s=0) or power-good (s=1) to reach a level
  task automatic wait_sig(input int s, input logic v);
    int n = 0;
    while (((s == 1) ? pg : gate) !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) fail_count++;
  endtask : wait_sig

  // lowest active limit, start-up terms only while power-good is low
  function automatic logic [11:0] exp_lim(input logic [11:0] n, s, f,
      input logic [3:0] c, input logic p);
    logic [11:0] m;
    logic [15:0] prod;
    m = (n < f) ? n : f;
    prod = ({4'h0, n} * {12'h0, c}) >> 4;
    if (!p && s < m) m = s;
    if (!p && prod[11:0] < m) m = prod[11:0];
    return m;
  endfunction : exp_lim

  task automatic finish_test;
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(90177));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b1, OFS_CTRL, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ofs[i], 32'h0);
      chk(rd, rst_val[i]);
    end
    // random references and start-up codes while disabled
    for (int i = 0; i < 12; i++) begin
      code = (i == 0) ? 4'h0 : 4'($urandom_range(15));
      nref <= 12'($urandom);
      sref <= 12'($urandom);
      fref <= 12'($urandom);
      wb(1'b1, OFS_LIMIT, {28'h0, code});
      chk(lim, exp_lim(nref, sref, fref, code, 1'b0));
      chk(gate, 1'b0);
      chk(gate_lo, 1'b0);
    end
    en <= 1'b1;
    wait_sig(1, 1'b1);
    chk(pg, 1'b1);
    chk(gate_lo, 1'b1);
    @(posedge clk_i);
    chk(lim, exp_lim(nref, sref, fref, code, 1'b1));
    // overcurrent with latch-off
    wb(1'b1, OFS_MASK, 32'h1);
    flt <= 4'h4;
    repeat (3) @(posedge clk_i);
    chk(gate, 1'b0);
    chk({fault, irq, oe1, oe2}, 4'hF);
    flt <= 4'h0;
    repeat (30) @(posedge clk_i);
    chk({fault, gate}, 2'h2);
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h12);
    wb(1'b0, OFS_IRQ, 32'h0);
    chk(rd, 32'h9);
    wb(1'b1, OFS_IRQ, 32'hF);
    chk({irq, oe1, oe2}, 3'h0);
    en <= 1'b0;
    repeat (3) @(posedge clk_i);
    en <= 1'b1;
    wait_sig(0, 1'b1);
    chk(fault, 1'b0);
    // overtemperature, then fet health
    for (int k = 0; k < 2; k++) begin
      flt <= k ? 4'h1 : 4'h2;
      repeat (3) @(posedge clk_i);
      chk(fault, 1'b1);
      flt <= 4'h0;
      en <= 1'b0;
      repeat (3) @(posedge clk_i);
      en <= 1'b1;
      wait_sig(0, 1'b1);
    end
    flt <= 4'h8;
    repeat (3) @(posedge clk_i);
    chk(gate, 1'b0);
    flt <= 4'h0;
    wait_sig(0, 1'b1);
    // overcurrent with auto retry and a slow fet
    rsel <= 1'b0;
    slow <= 1'b1;
    flt <= 4'h4;
    repeat (2) @(posedge clk_i);
    flt <= 4'h0;
    repeat (RC / 2) @(posedge clk_i);
    chk(fault, 1'b1);
    wait_sig(0, 1'b1);
    chk(fault, 1'b0);
    for (int i = 0; i < 16; i++) begin
      strap <= 4'(i);
      repeat (3) @(posedge clk_i);
      chk(badr, 7'h40 | 7'(i));
    end
    wb(1'b0, OFS_ADDR, 32'h0);
    chk(rd, 32'h4F);
    // pin one as conversion input
    wb(1'b1, OFS_PINCFG, 32'h32);
    conversion_trigger <= 1'b1;
    @(posedge clk_i);
    conversion_trigger <= 1'b0;
    hits = 0;
    repeat (6) begin
      @(posedge clk_i);
      hits += (trig === 1'b1);
    end
    chk(hits, 32'h1);
    // general outputs; a conversion mode on pin two is ignored
    wb(1'b1, OFS_PINCFG, 32'h19);
    wb(1'b0, OFS_PINCFG, 32'h0);
    chk(rd, 32'h11);
    chk({oe1, oe2}, 2'h1);
    wb(1'b1, OFS_PINCFG, 32'h05);
    chk({oe1, oe2}, 2'h3);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
